// >>> rtl/sice_top.v
`timescale 1ns/1ps
`include "sice_defs.vh"

// Overview of operation
// - Registers are 8, 16 or 32 bits; 8/16/32-bit accesses are atomic.
// - Bytes and halfwords of 32-bit registers, bytes of 16-bit ones, reachable alone.
// - PLL state register is read through a synchroniser; others are direct.
// - Write-protected registers ignore writes while access protection is on.
// - Enable clear register at 0x00, 32 bits, resets to zero, write-protected.
// - Writing 0 to an enable bit leaves it unchanged.
// - Writing 1 to bit 17 clears the PLL lock timeout enable.
// - Writing 1 to bit 16 clears the PLL lock lost enable.
// - Writing 1 to bit 15 clears the PLL lock gained enable.
// - Writing 1 to bit 11 clears the brown-out sync ready enable.
// - An enabled source with its flag set requests an interrupt; disabled never.
// - Bits 7..0 map to loop locks, bounds, ready and oscillator ready enables.
module sice_top (
	input wire i_ref_clk, // Peripheral bus clock
	input wire i_rst, // Sync reset, active high
	input wire i_wr_en, // Write strobe
	input wire i_rd_en, // Read strobe
	input wire [7:0] i_addr, // Byte address, word aligned
	input wire [3:0] i_byte_en, // Byte lanes
	input wire [31:0] i_wdata, // Write data
	input wire i_wp_on, // Access protection active
	input wire [31:0] i_irq_flags, // Interrupt flags, same clock
	input wire [7:0] i_pll_state, // PLL state from other domain
	output reg [31:0] o_rdata, // Read data
	output reg o_rvalid, // Read data valid pulse
	output reg o_irq, // Interrupt request
	output reg [15:0] o_core_reg, // Core regulator control
	output reg [31:0] o_ref_volt, // Reference voltage control
	output reg [7:0] o_pll_ctrl_a, // PLL control A
	output reg [31:0] o_pll_ratio, // PLL ratio
	output reg [31:0] o_pll_ctrl_b // PLL control B
);

	wire [31:0] enable;
	wire wr_ok;
	wire set_wr;
	wire clr_wr;
	reg [7:0] state_s1_reg;
	reg [7:0] state_s2_reg;
	reg [7:0] state_s3_reg;
	reg [7:0] state_sync_reg;
	reg [31:0] rdata_next;
	reg [15:0] core_next;
	reg [31:0] ref_volt_next;
	reg [7:0] pll_ctrl_a_next;
	reg [31:0] pll_ratio_next;
	reg [31:0] pll_ctrl_b_next;
	reg [31:0] core_wide;
	reg [31:0] ctrl_a_wide;
	wire [31:0] pending;

	function [31:0] lane_mask;
		input [3:0] be;
		begin
			lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		end
	endfunction

	function [31:0] merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0] be;
		input [31:0] width_mask;
		reg [31:0] m;
		begin
			m = lane_mask(be) & width_mask;
			merge = (old_val & ~m) | (new_val & m);
		end
	endfunction

	assign wr_ok = i_wr_en & ~i_wp_on;
	assign set_wr = wr_ok & (i_addr == `SICE_OFS_EN_SET);
	assign clr_wr = wr_ok & (i_addr == `SICE_OFS_EN_CLEAR);

	sice_en_bank u_en_bank (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_set_wr(set_wr),
		.i_clr_wr(clr_wr),
		.i_byte_en(i_byte_en),
		.i_wdata(i_wdata),
		.o_enable(enable)
	);

	// Synchroniser for the PLL state; update once stages two and three agree
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			state_s1_reg <= 8'h00;
			state_s2_reg <= 8'h00;
			state_s3_reg <= 8'h00;
			state_sync_reg <= 8'h00;
		end else begin
			state_s1_reg <= i_pll_state;
			state_s2_reg <= state_s1_reg;
			state_s3_reg <= state_s2_reg;
			if (state_s2_reg == state_s3_reg) begin
				state_sync_reg <= state_s3_reg;
			end
		end
	end

	// Next values of the storage registers, lanes kept within the register width
	always @* begin
		core_wide = merge({16'h0000, o_core_reg}, i_wdata, i_byte_en,
			`SICE_MASK_W16);
		ctrl_a_wide = merge({24'h000000, o_pll_ctrl_a}, i_wdata, i_byte_en,
			`SICE_MASK_W8);
		core_next = o_core_reg;
		ref_volt_next = o_ref_volt;
		pll_ctrl_a_next = o_pll_ctrl_a;
		pll_ratio_next = o_pll_ratio;
		pll_ctrl_b_next = o_pll_ctrl_b;
		if (wr_ok) begin
			case (i_addr)
				`SICE_OFS_CORE_REG: begin
					core_next = core_wide[15:0];
				end
				`SICE_OFS_REF_VOLT: begin
					ref_volt_next = merge(o_ref_volt, i_wdata, i_byte_en,
						`SICE_MASK_W32);
				end
				`SICE_OFS_PLL_CTRL_A: begin
					pll_ctrl_a_next = ctrl_a_wide[7:0];
				end
				`SICE_OFS_PLL_RATIO: begin
					pll_ratio_next = merge(o_pll_ratio, i_wdata, i_byte_en,
						`SICE_MASK_W32);
				end
				`SICE_OFS_PLL_CTRL_B: begin
					pll_ctrl_b_next = merge(o_pll_ctrl_b, i_wdata, i_byte_en,
						`SICE_MASK_W32);
				end
				default: begin
					pll_ctrl_b_next = o_pll_ctrl_b;
				end
			endcase
		end
	end

	// Storage registers
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_core_reg <= 16'h0000;
			o_ref_volt <= `SICE_RST_WORD;
			o_pll_ctrl_a <= 8'h00;
			o_pll_ratio <= `SICE_RST_WORD;
			o_pll_ctrl_b <= `SICE_RST_WORD;
		end else begin
			o_core_reg <= core_next;
			o_ref_volt <= ref_volt_next;
			o_pll_ctrl_a <= pll_ctrl_a_next;
			o_pll_ratio <= pll_ratio_next;
			o_pll_ctrl_b <= pll_ctrl_b_next;
		end
	end

	// Read mux; unmapped addresses read zero
	always @* begin
		case (i_addr)
			`SICE_OFS_EN_CLEAR: begin
				rdata_next = enable & `SICE_EN_IMPL_MASK;
			end
			`SICE_OFS_EN_SET: begin
				rdata_next = enable & `SICE_EN_IMPL_MASK;
			end
			`SICE_OFS_CORE_REG: begin
				rdata_next = {16'h0000, o_core_reg};
			end
			`SICE_OFS_REF_VOLT: begin
				rdata_next = o_ref_volt;
			end
			`SICE_OFS_PLL_CTRL_A: begin
				rdata_next = {24'h000000, o_pll_ctrl_a};
			end
			`SICE_OFS_PLL_RATIO: begin
				rdata_next = o_pll_ratio;
			end
			`SICE_OFS_PLL_CTRL_B: begin
				rdata_next = o_pll_ctrl_b;
			end
			`SICE_OFS_PLL_STATE: begin
				rdata_next = {24'h000000, state_sync_reg};
			end
			default: begin
				rdata_next = 32'h00000000;
			end
		endcase
		// Unselected byte lanes read zero
		rdata_next = rdata_next & lane_mask(i_byte_en);
	end

	// Sources both flagged and enabled
	assign pending = i_irq_flags & enable & `SICE_EN_IMPL_MASK;

	// Read port
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_rdata <= 32'h00000000;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_rd_en;
			if (i_rd_en) begin
				o_rdata <= rdata_next;
			end
		end
	end

	// Interrupt request, one cycle after a flag or enable change
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |pending;
		end
	end

endmodule // sice_top

// >>> rtl/sice_defs.vh
`ifndef SICE_DEFS_VH
`define SICE_DEFS_VH

// Register offsets (byte addresses)
`define SICE_OFS_EN_CLEAR 8'h00
`define SICE_OFS_EN_SET 8'h04
`define SICE_OFS_CORE_REG 8'h3C
`define SICE_OFS_REF_VOLT 8'h40
`define SICE_OFS_PLL_CTRL_A 8'h44
`define SICE_OFS_PLL_RATIO 8'h48
`define SICE_OFS_PLL_CTRL_B 8'h4C
`define SICE_OFS_PLL_STATE 8'h50

// Reset values
`define SICE_RST_EN 32'h00000000
`define SICE_RST_WORD 32'h00000000

// Implemented enable bits: 17..15 and 11..0
`define SICE_EN_IMPL_MASK 32'h00038FFF

// Enable field positions
`define SICE_BIT_XTAL_RDY 0
`define SICE_BIT_XTAL32K_RDY 1
`define SICE_BIT_RC32K_RDY 2
`define SICE_BIT_RC8M_RDY 3
`define SICE_BIT_FLL_RDY 4
`define SICE_BIT_FLL_OOB 5
`define SICE_BIT_FLL_FINE 6
`define SICE_BIT_FLL_COARSE 7
`define SICE_BIT_FLL_REFSTOP 8
`define SICE_BIT_BOD_RDY 9
`define SICE_BIT_BOD_DET 10
`define SICE_BIT_BOD_SYNC 11
`define SICE_BIT_PLL_GAINED 15
`define SICE_BIT_PLL_LOST 16
`define SICE_BIT_PLL_TIMEOUT 17

// Widths of the storage registers
`define SICE_MASK_W8 32'h000000FF
`define SICE_MASK_W16 32'h0000FFFF
`define SICE_MASK_W32 32'hFFFFFFFF

`endif

// >>> rtl/sice_en_bank.v
`timescale 1ns/1ps
`include "sice_defs.vh"

module sice_en_bank (
	input wire i_ref_clk, // Clock
	input wire i_rst, // Sync reset, active high
	input wire i_set_wr, // Write to the set view
	input wire i_clr_wr, // Write to the clear view
	input wire [3:0] i_byte_en, // Byte lanes of the write
	input wire [31:0] i_wdata, // Write data
	output wire [31:0] o_enable // Shared enable vector
);

	reg [31:0] enable_reg;
	reg [31:0] enable_next;
	reg [31:0] hit;

	function [31:0] lane_mask;
		input [3:0] be;
		begin
			lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		end
	endfunction

	always @* begin
		hit = i_wdata & lane_mask(i_byte_en) & `SICE_EN_IMPL_MASK;
		enable_next = enable_reg;
		if (i_clr_wr) begin
			enable_next = enable_reg & ~hit;
		end
		if (i_set_wr) begin
			enable_next = enable_reg | hit;
		end
	end

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			enable_reg <= `SICE_RST_EN;
		end else begin
			enable_reg <= enable_next;
		end
	end

	assign o_enable = enable_reg;

endmodule // sice_en_bank

// >>> dv/sice_chk.sv
`timescale 1ns/1ps
module sice_chk (
	input wire i_ref_clk, // Clock
	input wire i_rst, // Reset
	input wire i_wr_en, // Write
	input wire i_rd_en, // Read
	input wire [7:0] i_addr, // Address
	input wire [3:0] i_byte_en, // Lanes
	input wire [31:0] i_wdata, // Data
	input wire i_wp_on, // Protect
	input wire [31:0] i_irq_flags, // Flags
	input wire [31:0] o_rdata, // Rdata
	input wire o_rvalid, // Valid
	input wire o_irq, // Irq
	input wire [31:0] o_ref_volt, // Ref
	input wire [7:0] o_pll_ctrl_a // Ctl
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	wire wall = i_wr_en && !i_wp_on && i_byte_en == 4'hF;
	rd_pulse_a: assert property (i_rd_en |=> o_rvalid) else $error("no rvalid");
	rd_only_a: assert property (!i_rd_en |=> !o_rvalid) else $error("stray rvalid");
	rsvd_zero_a: assert property (o_rvalid && $past(i_addr) == 8'h00 |->
		(o_rdata & 32'hFFFC7000) == 32'h0) else $error("reserved set");
	no_flag_a: assert property (i_irq_flags == 32'h0 |=> !o_irq) else $error("bad irq");
	wp_block_a: assert property (i_wr_en && i_wp_on |=>
		$stable(o_ref_volt)) else $error("wp write");
	clr_irq_a: assert property (wall && i_addr == 8'h00 && i_wdata == 32'hFFFFFFFF ##1
		!i_wr_en |=> !o_irq) else $error("irq kept");
	set_irq_a: assert property (wall && i_addr == 8'h04 && i_wdata == 32'h1 ##1
		!i_wr_en && i_irq_flags[0] |=> o_irq) else $error("irq lost");
	byte_lane_a: assert property (i_wr_en && !i_wp_on && i_addr == 8'h44 && i_byte_en[0] |=>
		o_pll_ctrl_a == $past(i_wdata[7:0])) else $error("byte lost");
	cover property (o_irq);
	cover property (o_rvalid);
	cover property (i_wr_en && i_wp_on);
endmodule // sice_chk
bind sice_top sice_chk sice_chk_inst (.*);

// >>> dv/tb_sice_top.sv
`timescale 1ns/1ps
module tb_sice_top;
	logic i_ref_clk = 1'h0, i_rst = 1'h1, i_wr_en = 1'h0, i_rd_en = 1'h0, i_wp_on = 1'h0;
	logic [7:0] i_addr = '0, i_pll_state = '0, o_pll_ctrl_a;
	logic [3:0] i_byte_en = '0;
	logic [31:0] i_wdata = '0, i_irq_flags = '0, o_rdata, o_ref_volt;
	logic [31:0] o_pll_ratio, o_pll_ctrl_b;
	logic [15:0] o_core_reg;
	logic o_rvalid, o_irq;
	int n_mismatch = 0, n_checks = 0;
	sice_top sice_top_inst (.*);
	initial forever #10 i_ref_clk = ~i_ref_clk;
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		@(posedge i_ref_clk) #1;
		{i_wr_en, i_addr, i_byte_en, i_wdata} = {1'h1, a, b, d};
		@(posedge i_ref_clk) #1;
		i_wr_en = 1'h0;
	endtask
	task automatic rdb(input logic [7:0] a, input logic [3:0] b, input logic [31:0] e);
		@(posedge i_ref_clk) #1;
		{i_rd_en, i_addr, i_byte_en} = {1'h1, a, b};
		@(posedge i_ref_clk) #1;
		i_rd_en = 1'h0;
		chk("rvalid", {31'h0, o_rvalid}, 32'h1);
		chk("rdata", o_rdata, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rdb(a, 4'hF, e);
	endtask
	task automatic irq_is(input logic e);
		repeat (2) @(posedge i_ref_clk);
		#1;
		chk("irq", {31'h0, o_irq}, {31'h0, e});
	endtask
	task t_regs;
		rd(8'h00, 32'h0);
		wr(8'h04, 4'hF, 32'hFFFFFFFF);
		rd(8'h00, 32'h00038FFF);
		wr(8'h00, 4'hF, 32'h0);
		rd(8'h04, 32'h00038FFF);
		wr(8'h00, 4'h4, 32'h00020000);
		rd(8'h00, 32'h00018FFF);
		wr(8'h00, 4'h4, 32'h00010000);
		rd(8'h00, 32'h00008FFF);
		wr(8'h00, 4'h2, 32'h00008800);
		rd(8'h00, 32'h000007FF);
		wr(8'h00, 4'h1, 32'h000007FF);
		rd(8'h00, 32'h00000700);
		$display("regs done");
	endtask
	task t_wp;
		i_wp_on = 1'h1;
		wr(8'h00, 4'hF, 32'hFFFFFFFF);
		wr(8'h40, 4'hF, 32'hFFFFFFFF);
		i_wp_on = 1'h0;
		rd(8'h00, 32'h00000700);
		chk("ref", o_ref_volt, 32'h0);
		wr(8'h40, 4'hC, 32'hABCD1234);
		chk("ref", o_ref_volt, 32'hABCD0000);
		$display("wp done");
	endtask
	task t_irq;
		i_irq_flags = 32'hFFFC7000;
		irq_is(1'h0);
		i_irq_flags = 32'h00000100;
		irq_is(1'h1);
		i_irq_flags = 32'h1;
		wr(8'h04, 4'hF, 32'h1);
		irq_is(1'h1);
		wr(8'h00, 4'hF, 32'hFFFFFFFF);
		irq_is(1'h0);
		$display("irq done");
	endtask
	task t_pll;
		wr(8'h44, 4'hF, 32'hFFFFFFA5);
		chk("ctla", {24'h0, o_pll_ctrl_a}, 32'hA5);
		wr(8'h44, 4'h2, 32'h0000FF00);
		chk("ctla", {24'h0, o_pll_ctrl_a}, 32'hA5);
		wr(8'h3C, 4'hF, 32'hFFFFFFFF);
		chk("core", {16'h0, o_core_reg}, 32'hFFFF);
		wr(8'h3C, 4'h1, 32'h00000012);
		rdb(8'h3C, 4'h2, 32'h0000FF00);
		chk("core", {16'h0, o_core_reg}, 32'hFF12);
		wr(8'h48, 4'h3, 32'h89ABCDEF);
		rd(8'h48, 32'h0000CDEF);
		wr(8'h4C, 4'hF, 32'h13579BDF);
		chk("ratio", o_pll_ratio, 32'h0000CDEF);
		chk("ctlb", o_pll_ctrl_b, 32'h13579BDF);
		i_pll_state = 8'h5A;
		repeat (6) @(posedge i_ref_clk);
		#1;
		rd(8'h50, 32'h5A);
		rd(8'h80, 32'h0);
		$display("pll done");
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge i_ref_clk);
		#1 i_rst = 1'h0;
		t_regs;
		t_wp;
		t_irq;
		t_pll;
		tally_and_finish;
	end
	initial begin
		#20000;
		n_mismatch++;
		tally_and_finish;
	end
endmodule // tb_sice_top
